// [rtl/rfm_defs.svh]
// register offsets, thresholds and timing counts of the fault monitor
`ifndef RFM_DEFS_SVH
`define RFM_DEFS_SVH
// read-only register offsets
`define RFM_TEMP_OFF   8'h17
`define RFM_MAX_CURRENT_PROGRAM_PIN_OFF   8'h21
`define RFM_CURRENT_REPORT_PIN_OFF   8'h15
// clock rate and latch-off time
`define RFM_CLK_MHZ    50
`define RFM_OC_TIME_NS 50000
`define RFM_OC_CYC     ((`RFM_OC_TIME_NS * `RFM_CLK_MHZ + 999) / 1000)
// reference ramp: one code step per period
`define RFM_RAMP_NS    1000
`define RFM_RAMP_CYC   ((`RFM_RAMP_NS * `RFM_CLK_MHZ) / 1000)
// converter codes: 2 V on the current report pin is code 10'h200
`define RFM_CURRENT_REPORT_PIN_FS_SH 9
`define RFM_TEMP_BASE  10'h2a8
`define RFM_ALERT_TH   10'h0c0
`define RFM_HOT_TH     10'h0a0
`endif

// [rtl/rfm_monitor.sv]
// fault handling and telemetry of a single-phase buck regulator
// Behaviour
// R1 - current above lower limit starts the latch-off timer
// R2 - lower-limit fault still present at 50 us shuts down and latches
// R3 - current above fast limit (150 percent) shuts down at once
// R4 - overcurrent latch clears only by enable low then high
// R5 - max-current register 21h loaded from program pin at enable
// R6 - max-current register weight is one ampere per bit
// R7 - current report digitized, 2 V equals programmed max current
// R8 - control or input supply undervoltage disables power outputs (code: only in soft start and run; ignored in overvoltage ramp and hold)
// R9 - after supplies recover a new soft start begins
// R10 - output below target by margin drives ready flag low
// R11 - overvoltage forces high-side gate low, low-side gate high
// R12 - after overvoltage trip reference ramps slowly to zero
// R13 - during ramp low-side gate follows output above reference plus margin
// R14 - reference at zero holds high-side low, low-side high
// R15 - overvoltage shutdown latched until enable cycled low
// R16 - during soft start fixed 2.9 V overvoltage threshold is used
// R17 - temperature input sampled, converted, stored in register 17h
// R18 - temperature crossing thresholds asserts alert or overheat flag
// R19 - temperature sensing and alerts active in normal operation
// R20 - current falling below lower limit clears the timer
`timescale 1ns/1ns
`include "rfm_defs.svh"
module rfm_monitor (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // analog comparators, enable pin and converter words
  input  wire rfm_pkg::rfm_pins_type pins,
  input  wire rfm_pkg::rfm_adc_type  adc,
  // modulator and voltage target, same clock
  input  wire logic                 pwm_in,
  input  wire logic [7:0]           vid_target,
  // register read port of the serial bus logic
  input  wire logic [7:0]           reg_addr,
  output logic      [7:0]           reg_rdata,
  // power stage and reference
  output logic                      high_side_gate_ctl,
  output logic                      low_side_gate_ctl,
  output logic                      power_on,
  output logic      [7:0]           dac_code,
  // status flags
  output logic                      regulator_ready_flag,
  output logic                      alert_n,
  output logic                      overheat_flag_n
);
  localparam logic [11:0] OC_LAST   = 12'(`RFM_OC_CYC - 1);
  localparam logic [5:0]  RAMP_LAST = 6'(`RFM_RAMP_CYC - 1);

  rfm_pkg::rfm_state_type r;
  rfm_pkg::rfm_state_type n;
  logic [17:0] current_report_pin_prod;
  logic [9:0]  temp_diff;
  logic        live;
  logic        supply_uv;
  logic        oc_trip;

  assign live      = (r.mode == rfm_pkg::st_soft) || (r.mode == rfm_pkg::st_run);
  assign supply_uv = r.s2.vcc_uv || r.s2.vin_uv;
  assign oc_trip   = r.s2.lim_hi || (r.s2.lim_lo && r.oc_cnt == OC_LAST);
  // amps = code * max_current / code of 2 V
  assign current_report_pin_prod = {8'h00, r.smp.current_report_pin} * {10'h000, r.max_cur}; // R7
  // hotter thermistor gives lower voltage, so temperature rises as code falls
  assign temp_diff = (r.smp.temp > `RFM_TEMP_BASE) ? 10'h000 :
                     `RFM_TEMP_BASE - r.smp.temp;

  // next-state logic of the whole block
  always_comb begin
    n       = r;
    n.s1    = pins;
    n.s2    = r.s1;
    n.tgl_d = r.s2.adc_tgl;
    // words are read only after the synchronised toggle, when they are stable
    if (r.s2.adc_tgl != r.tgl_d) begin
      n.smp = adc;
    end
    n.tick = 1'b0;
    if (r.ramp_cnt == RAMP_LAST) begin
      n.ramp_cnt = 6'h00;
      n.tick     = 1'b1;
    end else begin
      n.ramp_cnt = r.ramp_cnt + 6'h01;
    end
    case (r.mode)
      rfm_pkg::st_off: begin
        n.dac = 8'h00;
        if (r.s2.en) begin
          n.max_cur = {1'b0, r.smp.max_current_program_pin[9:3]}; // R5 R6
          n.mode    = rfm_pkg::st_soft;
        end
      end
      rfm_pkg::st_soft, rfm_pkg::st_run: begin
        if (r.mode == rfm_pkg::st_run) begin
          n.dac = vid_target;
        end else if (r.dac >= vid_target) begin
          n.dac  = vid_target;
          n.mode = rfm_pkg::st_run;
        end else if (r.tick) begin
          n.dac = r.dac + 8'h01;
        end
        if (supply_uv) begin
          n.mode = rfm_pkg::st_supply_undervolt_lockout; // R8
        end
        // fixed threshold while starting avoids false trips
        if (r.mode == rfm_pkg::st_soft ? r.s2.ov_fixed : r.s2.ov_ref) begin
          n.mode = rfm_pkg::st_ov_ramp; // R11 R16
        end
        if (r.s2.lim_lo) begin
          n.oc_cnt = r.oc_cnt + 12'h001; // R1
        end else begin
          n.oc_cnt = 12'h000; // R20
        end
        if (oc_trip) begin
          n.mode = rfm_pkg::st_oc; // R2 R3
        end
      end
      rfm_pkg::st_supply_undervolt_lockout: begin
        n.dac = 8'h00;
        if (!supply_uv) begin
          n.mode = rfm_pkg::st_soft; // R9
        end
      end
      rfm_pkg::st_ov_ramp: begin
        // slow ramp keeps the output from swinging negative
        if (r.dac == 8'h00) begin
          n.mode = rfm_pkg::st_ov_hold;
        end else if (r.tick) begin
          n.dac = r.dac - 8'h01; // R12
        end
      end
      rfm_pkg::st_oc, rfm_pkg::st_ov_hold: begin
        n.mode = r.mode; // R4 R15
      end
      default: begin
        n.mode = rfm_pkg::st_off;
      end
    endcase
    if (n.mode != rfm_pkg::st_soft && n.mode != rfm_pkg::st_run) begin
      n.oc_cnt = 12'h000;
    end
    // only an enable low clears the latched faults
    if (!r.s2.en) begin
      n.mode = rfm_pkg::st_off; // R4 R15
    end
    n.pwr_on = (n.mode == rfm_pkg::st_soft) || (n.mode == rfm_pkg::st_run) ||
               (n.mode == rfm_pkg::st_ov_ramp) ||
               (n.mode == rfm_pkg::st_ov_hold);
    // gate controls follow the next mode, so they change with it
    case (n.mode)
      rfm_pkg::st_soft, rfm_pkg::st_run: begin
        n.gh = pwm_in;
        n.gl = !pwm_in;
      end
      rfm_pkg::st_ov_ramp: begin
        n.gh = 1'b0; // R11
        n.gl = (r.mode != rfm_pkg::st_ov_ramp) || r.s2.ov_ref; // R11 R13
      end
      rfm_pkg::st_ov_hold: begin
        n.gh = 1'b0; // R14
        n.gl = 1'b1; // R14
      end
      default: begin
        n.gh = 1'b0;
        n.gl = 1'b0;
      end
    endcase
    n.ready    = (n.mode == rfm_pkg::st_run) && !r.s2.out_uv; // R10
    n.current_report_pin_val = current_report_pin_prod[17] ? 8'hff :
                 current_report_pin_prod[`RFM_CURRENT_REPORT_PIN_FS_SH+7:`RFM_CURRENT_REPORT_PIN_FS_SH]; // R7
    // thermal path runs only in normal operation
    if (n.mode == rfm_pkg::st_run) begin // R19
      n.temp_val = temp_diff[9:2]; // R17
      n.alert_n  = !(r.smp.temp < `RFM_ALERT_TH); // R18
      n.hot_n    = !(r.smp.temp < `RFM_HOT_TH); // R18
    end else begin
      n.alert_n = 1'b1;
      n.hot_n   = 1'b1;
    end
    case (reg_addr)
      `RFM_TEMP_OFF: n.rdata = r.temp_val; // R17
      `RFM_MAX_CURRENT_PROGRAM_PIN_OFF: n.rdata = r.max_cur; // R5
      `RFM_CURRENT_REPORT_PIN_OFF: n.rdata = r.current_report_pin_val; // R7
      default:       n.rdata = 8'h00;
    endcase
  end

  // state register; alert and overheat flags are active low, so they reset high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r         <= '0;
      r.alert_n <= 1'b1;
      r.hot_n   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata            = r.rdata;
  assign high_side_gate_ctl   = r.gh;
  assign low_side_gate_ctl    = r.gl;
  assign power_on             = r.pwr_on;
  assign dac_code             = r.dac;
  assign regulator_ready_flag = r.ready;
  assign alert_n              = r.alert_n;
  assign overheat_flag_n      = r.hot_n;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_ov_entry;
    (r.mode != rfm_pkg::st_ov_ramp) ##1 (r.mode == rfm_pkg::st_ov_ramp);
  endsequence

  a_oc_timer_start: assert property ( // R1
    (live && r.s2.en && r.s2.lim_lo && r.oc_cnt == 12'h000 && !r.s2.lim_hi)
    |=> (r.oc_cnt == 12'h001 || !live))
    else $error("latch-off timer did not start");
  a_oc_timer_expiry: assert property ( // R2
    (live && r.s2.en && r.s2.lim_lo && r.oc_cnt == OC_LAST)
    |=> (r.mode == rfm_pkg::st_oc && !r.pwr_on))
    else $error("no shutdown at latch-off time");
  a_oc_fast_trip: assert property ( // R3
    (live && r.s2.en && r.s2.lim_hi) |=> (r.mode == rfm_pkg::st_oc))
    else $error("fast limit did not shut down");
  a_oc_latch_held: assert property ( // R4
    (r.mode == rfm_pkg::st_oc && r.s2.en) |=> (r.mode == rfm_pkg::st_oc))
    else $error("overcurrent latch released with enable high");
  a_max_current_program_pin_load: assert property ( // R5
    (r.mode == rfm_pkg::st_off && r.s2.en)
    |=> ({2'b00, r.max_cur} == ($past(r.smp.max_current_program_pin) >> 3)))
    else $error("max current not loaded at enable");
  a_supply_undervolt_lockout_power_off: assert property ( // R8
    (live && r.s2.en && supply_uv && !oc_trip) |=> !r.pwr_on)
    else $error("power on during supply undervoltage");
  a_supply_undervolt_lockout_restart: assert property ( // R9
    (r.mode == rfm_pkg::st_supply_undervolt_lockout && r.s2.en && !supply_uv)
    |=> (r.mode == rfm_pkg::st_soft && r.dac == 8'h00))
    else $error("no soft start after supply recovery");
  a_ready_drop: assert property ( // R10
    r.s2.out_uv |=> !r.ready)
    else $error("ready high with output undervoltage");
  a_ov_trip_gates: assert property ( // R11
    s_ov_entry |-> (!r.gh && r.gl))
    else $error("wrong gates on overvoltage trip");
  a_ov_ramp_step: assert property ( // R12
    (r.mode == rfm_pkg::st_ov_ramp && r.s2.en && r.tick && r.dac != 8'h00)
    |=> (r.dac == $past(r.dac) - 8'h01))
    else $error("reference did not step down");
  a_ov_hold_latch: assert property ( // R15
    (r.mode == rfm_pkg::st_ov_hold && r.s2.en)
    |=> (r.mode == rfm_pkg::st_ov_hold && !r.gh && r.gl)) // R14
    else $error("overvoltage hold released");
  a_ss_fixed_ov: assert property ( // R16
    (r.mode == rfm_pkg::st_soft && r.s2.en && r.s2.ov_fixed && !oc_trip)
    |=> (r.mode == rfm_pkg::st_ov_ramp))
    else $error("fixed threshold ignored in soft start");
  a_alert_idle: assert property ( // R19
    (r.mode != rfm_pkg::st_run) ##1 (r.mode != rfm_pkg::st_run)
    |-> (r.alert_n && r.hot_n))
    else $error("thermal flag outside normal operation");

  // run with no fault pending, so the mode is still run at the next edge
  sequence s_run_quiet;
    r.mode == rfm_pkg::st_run && r.s2.en && !supply_uv && !oc_trip &&
    !r.s2.ov_ref;
  endsequence

  a_oc_timer_clear: assert property ( // R20
    (live && r.s2.en && !r.s2.lim_lo) |=> (r.oc_cnt == 12'h000))
    else $error("latch-off timer not cleared");
  a_en_low_clear: assert property ( // R4 R15
    !r.s2.en |=> (r.mode == rfm_pkg::st_off && !r.pwr_on))
    else $error("enable low did not clear the block");
  // overcurrent and supply lockout modes keep the whole power stage quiet
  a_oc_gates_off: assert property ( // R2
    (r.mode == rfm_pkg::st_oc) |-> (!r.gh && !r.gl && !r.pwr_on))
    else $error("power stage on in overcurrent latch");
  a_supply_undervolt_lockout_gates_off: assert property ( // R8
    (r.mode == rfm_pkg::st_supply_undervolt_lockout) |-> (!r.gh && !r.gl && !r.pwr_on))
    else $error("power stage on in supply lockout");
  a_max_current_program_pin_held: assert property ( // R5
    (r.mode != rfm_pkg::st_off) |=> $stable(r.max_cur))
    else $error("max current changed after enable");
  a_current_report_pin_full_scale: assert property ( // R7
    (r.smp.current_report_pin == 10'h200) |=> (r.current_report_pin_val == $past(r.max_cur)))
    else $error("full scale report differs from max current");
  a_ov_ramp_follow: assert property ( // R13
    (r.mode == rfm_pkg::st_ov_ramp && r.s2.en && r.dac != 8'h00)
    |=> (!r.gh && r.gl == $past(r.s2.ov_ref)))
    else $error("low-side gate not following overvoltage");
  a_ov_hold_entry: assert property ( // R14
    (r.mode == rfm_pkg::st_ov_ramp && r.s2.en && r.dac == 8'h00)
    |=> (r.mode == rfm_pkg::st_ov_hold && !r.gh && r.gl))
    else $error("no hold when reference reached zero");
  a_ready_fault_low: assert property ( // R10
    (r.mode != rfm_pkg::st_run) |-> !r.ready)
    else $error("ready high outside normal operation");
  // thermal flags in normal operation
  a_alert_set: assert property ( // R18
    s_run_quiet ##0 (r.smp.temp < `RFM_ALERT_TH) |=> !r.alert_n)
    else $error("alert not raised above threshold");
  a_hot_set: assert property ( // R18
    s_run_quiet ##0 (r.smp.temp < `RFM_HOT_TH) |=> !r.hot_n)
    else $error("overheat flag not raised");
  a_hot_has_alert: assert property ( // R18
    !r.hot_n |-> !r.alert_n)
    else $error("overheat flag without alert");
endmodule

// [rtl/rfm_pkg.sv]
// types of the regulator fault monitor
package rfm_pkg;
  typedef enum logic [2:0] {
    st_off     = 3'h0,
    st_soft    = 3'h1,
    st_run     = 3'h2,
    st_supply_undervolt_lockout    = 3'h3,
    st_oc      = 3'h4,
    st_ov_ramp = 3'h5,
    st_ov_hold = 3'h6
  } rfm_mode_type;

  // asynchronous comparator and pin levels
  typedef struct packed {
    logic en;
    logic lim_lo;
    logic lim_hi;
    logic vcc_uv;
    logic vin_uv;
    logic out_uv;
    logic ov_ref;
    logic ov_fixed;
    logic adc_tgl;
  } rfm_pins_type;

  // converter words, stable around each toggle of adc_tgl
  typedef struct packed {
    logic [9:0] max_current_program_pin;
    logic [9:0] current_report_pin;
    logic [9:0] temp;
  } rfm_adc_type;

  typedef struct packed {
    rfm_pins_type s1;
    rfm_pins_type s2;
    logic         tgl_d;
    rfm_mode_type mode;
    logic [11:0]  oc_cnt;
    logic [5:0]   ramp_cnt;
    logic         tick;
    logic [7:0]   dac;
    rfm_adc_type  smp;
    logic [7:0]   max_cur;
    logic [7:0]   current_report_pin_val;
    logic [7:0]   temp_val;
    logic         gh;
    logic         gl;
    logic         pwr_on;
    logic         ready;
    logic         alert_n;
    logic         hot_n;
    logic [7:0]   rdata;
  } rfm_state_type;
endpackage

// [testbench/rfm_host_model.sv]
// host-side model that reads telemetry registers
`timescale 1ns/1ns
module rfm_host_model (
  // clock
  input  wire logic       core_clk,
  // register read port
  output logic      [7:0] reg_addr,
  input  wire logic [7:0] reg_rdata
);
  initial reg_addr = 8'h00;
  // address held three edges, since contents may lag one extra cycle
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #2 reg_addr = a;
    repeat (3) @(posedge core_clk);
    #1 d = reg_rdata;
  endtask
endmodule

// [testbench/test_rfm_monitor.sv]
// self-checking bench of the regulator fault monitor
`timescale 1ns/1ns
module test_rfm_monitor;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  rfm_pkg::rfm_pins_type pins;
  rfm_pkg::rfm_adc_type  adc;
  logic                 pwm_in;
  logic [7:0]           vid_target, reg_addr, reg_rdata, dac_code, rd;
  logic                 gh, gl, pwr, rdy, alert_n, hot_n;
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  int                   tcnt = 0;

  rfm_monitor u_dut (.core_clk(core_clk), .rst(rst), .pins(pins),
    .adc(adc), .pwm_in(pwm_in), .vid_target(vid_target),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .high_side_gate_ctl(gh), .low_side_gate_ctl(gl), .power_on(pwr),
    .dac_code(dac_code), .regulator_ready_flag(rdy),
    .alert_n(alert_n), .overheat_flag_n(hot_n));
  rfm_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata));

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the roughly 5600 cycles of the run
  always @(posedge core_clk) begin
    tcnt++;
    if (tcnt == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // words settle first, then the toggle announces them
  task automatic conv(input logic [9:0] i, input logic [9:0] t);
    adc.current_report_pin = i;
    adc.temp = t;
    step(2);
    pins.adc_tgl = ~pins.adc_tgl;
    step(8);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    u_host.read(a, rd);
    #1 chk(nm, e, rd);
  endtask

  // enable, then wait for soft start to finish under a bound
  task automatic start();
    int i;
    pins.en = 1'b1;
    for (i = 0; i < 2000 && rdy !== 1'b1; i++)
      step(1);
    chk("ready", 8'h01, {7'h0, rdy});
    chk("power", 8'h01, {7'h0, pwr});
  endtask

  task automatic recycle();
    pins.en = 1'b0;
    step(6);
    start();
  endtask

  initial begin
    pins = '0;
    adc = '0;
    pwm_in = 1'b0;
    vid_target = 8'h03;
    step(6);
    chk("rst_out", 8'h03,
        {1'b0, gh, gl, pwr, rdy, dac_code[0], alert_n, hot_n});
    chk("rst_dac", 8'h00, dac_code);
    chk("rst_rdata", 8'h00, reg_rdata);
    rst = 1'b0;
    adc.max_current_program_pin = 10'h190;
    conv(10'h200, 10'h268);
    start();
    // program pin changes after enable must not reach the register
    adc.max_current_program_pin = 10'h080;
    conv(10'h200, 10'h268);
    rd_chk("max_cur", 8'h21, 8'h32);
    rd_chk("current_report_pin", 8'h15, 8'h32);
    rd_chk("temp", 8'h17, 8'h10);
    rd_chk("unmapped", 8'h40, 8'h00);
    pwm_in = 1'b1;
    step(3);
    chk("pwm_gh", 8'h01, {7'h0, gh});
    pwm_in = 1'b0;
    conv(10'h200, 10'h0b0);
    chk("alert", 8'h01, {6'h0, alert_n, hot_n});
    conv(10'h200, 10'h090);
    chk("hot", 8'h00, {6'h0, alert_n, hot_n});
    conv(10'h200, 10'h268);
    chk("cool", 8'h03, {6'h0, alert_n, hot_n});
    pins.out_uv = 1'b1;
    step(4);
    chk("uv_rdy", 8'h00, {7'h0, rdy});
    pins.out_uv = 1'b0;
    step(4);
    // a short fault restarts the timer
    pins.lim_lo = 1'b1;
    step(2000);
    pins.lim_lo = 1'b0;
    step(4);
    pins.lim_lo = 1'b1;
    step(2000);
    chk("oc_clr", 8'h01, {7'h0, pwr});
    step(480);
    chk("oc_run", 8'h01, {7'h0, pwr});
    step(30);
    chk("oc_off", 8'h00, {5'h0, gh, gl, pwr});
    pins.lim_lo = 1'b0;
    step(10);
    chk("oc_latch", 8'h00, {7'h0, pwr});
    recycle();
    pins.lim_hi = 1'b1;
    step(4);
    chk("fast_oc", 8'h00, {5'h0, gh, gl, pwr});
    pins.lim_hi = 1'b0;
    recycle();
    pins.vin_uv = 1'b1;
    step(4);
    chk("supply_undervolt_lockout", 8'h00, {7'h0, pwr});
    pins.vin_uv = 1'b0;
    step(3);
    chk("uv_soft", 8'h00, dac_code);
    chk("uv_pwr", 8'h01, {7'h0, pwr});
    start();
    pins.ov_ref = 1'b1;
    step(4);
    chk("ov_gate", 8'h01, {6'h0, gh, gl});
    pins.ov_ref = 1'b0;
    step(4);
    chk("ov_tgl", 8'h00, {6'h0, gh, gl});
    chk("ramp", 8'h01, {7'h0, dac_code >= 8'h02});
    for (int i = 0; i < 400 && dac_code !== 8'h00; i++)
      step(1);
    step(4);
    chk("ov_hold", 8'h01, {6'h0, gh, gl});
    chk("ov_dac", 8'h00, dac_code);
    step(20);
    chk("ov_latch", 8'h05, {5'h0, pwr, gh, gl});
    recycle();
    vid_target = 8'h20;
    pins.en = 1'b0;
    step(6);
    pins.en = 1'b1;
    step(10);
    pins.ov_ref = 1'b1;
    step(4);
    chk("soft_ref", 8'h01, {7'h0, pwr});
    pins.ov_ref = 1'b0;
    pins.ov_fixed = 1'b1;
    step(4);
    chk("soft_ov", 8'h01, {6'h0, gh, gl});
    give_verdict();
  end
endmodule
